// File: lc_params.svh
// constants for the light-curtain receiver control block
`ifndef LC_PARAMS_SVH
`define LC_PARAMS_SVH

// clock and timing, times in their own units
`define CLK_HZ            40000000
`define RESET_OPEN_MIN_MS 250
`define RESET_OPEN_MAX_MS 2000
`define FLASH_HALF_MS     250
`define NOISE_SCANS       4'h3

// register bus
`define ADDR_W            8
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_IRQ_STATUS    8'h08
`define REG_IRQ_CLEAR     8'h0C
`define REG_IRQ_ENABLE    8'h10
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

// control fields and reset values
`define CTRL_LATCH_BIT    0
`define CTRL_RESET        1'h0
`define IRQ_EN_RESET      4'h0

// status fields
`define ST_STATE_LSB      0
`define ST_OUT_BIT        3
`define ST_LED_LSB        4
`define ST_EMIT_LED_BIT   8
`define ST_CAUSE_LSB      9
`define ST_TEST_BIT       11

// interrupt bits
`define IRQ_W             4
`define IRQ_TRIP          0
`define IRQ_LOCKOUT       1
`define IRQ_RESET_OK      2
`define IRQ_TEST          3

`endif

// File: lc_pkg.sv
// types shared by the light-curtain receiver control block
package lc_pkg;
	typedef enum logic [2:0] {
		ST_POWERUP,
		ST_INPUT_FAULT,
		ST_RUN,
		ST_LATCHED,
		ST_LOCKOUT
	} state_t;

	typedef enum logic [1:0] {
		CAUSE_NONE,
		CAUSE_OUTPUT,
		CAUSE_OPTICAL,
		CAUSE_INTERNAL
	} cause_t;

	typedef struct packed {
		logic output_f;
		logic optical_f;
		logic internal_f;
		logic emitter_f;
	} fault_t;

	typedef struct packed {
		logic top_clear;
		logic bottom_clear;
		logic any_blocked;
		logic noise;
	} beams_t;

	typedef struct packed {
		logic top;
		logic bottom;
		logic red;
		logic green;
	} led_t;
endpackage

// File: light_curtain_ctrl.sv
// run-time control of a light-curtain receiver with an AXI4-Lite register slave
//
// Overview of operation
// - in run mode any blocked beam turns both safety outputs off at once.
// - trip mode restores outputs automatically when every beam is clear again.
// - latch mode after clearing keeps outputs off, green on, alignment LEDs flashing.
// - latch mode enables outputs only after a valid reset with beams clear in the first closed cycle and the pulse cycle.
// - a critical fault enters lockout: outputs off and diagnostic LED pattern.
// - lockout holds every safety output off until recovery.
// - receiver lockout ends by valid reset or power cycle; emitter only by power.
// - output fault: lockout, both alignment LEDs flash, red flashes, green off.
// - optical fault: lockout, top LED flashes, bottom off, red flashes, green off.
// - internal fault: alignment off, red flashes, green off; emitter LED stays on, flashing only for an emitter fault.
// - input open at power-up: red and green steady, alignment off, power cycle only.
// - input open while running is test mode: outputs off, red on, green flashes.
// - reset accepted only when the open phase lasts a quarter to two seconds.
// - latch mode demands a manual reset after each lockout; latch mode resets off, so power-up goes to run.
// - noise counts only when present on several consecutive scans.
`include "lc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module light_curtain_ctrl #(
	parameter int unsigned RESET_MIN_CYC = (`CLK_HZ / 1000) * `RESET_OPEN_MIN_MS,
	parameter int unsigned RESET_MAX_CYC = (`CLK_HZ / 1000) * `RESET_OPEN_MAX_MS,
	parameter int unsigned FLASH_CYC     = (`CLK_HZ / 1000) * `FLASH_HALF_MS
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// scanning and self-test results
	input  wire lc_pkg::beams_t        beams,
	input  wire logic                  scan_strobe,
	input  wire lc_pkg::fault_t        faults,
	input  wire logic                  reset_input_closed,
	// machine side
	output logic                       safety_output_a,
	output logic                       safety_output_b,
	// indicators
	output lc_pkg::led_t               leds,
	output logic                       emitter_led,
	output logic                       irq,
	// AXI4-Lite slave
	input  wire logic [`ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [`ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	lc_pkg::state_t           state_q;
	lc_pkg::cause_t           cause_q;
	lc_pkg::led_t             leds_d;
	logic                     latch_mode_q;
	logic                     emit_lock_q;
	logic [3:0]               noise_cnt_q;
	logic                     bad_q;
	logic                     test_q;
	logic [31:0]              flash_cnt_q;
	logic                     flash_q;
	logic                     out_on_d;
	logic                     reset_ok;
	logic                     valid_pulse;
	logic                     blocked;
	logic                     rx_fault;
	logic [`IRQ_W-1:0]        irq_status_q;
	logic [`IRQ_W-1:0]        irq_enable_q;
	logic [`IRQ_W-1:0]        irq_event;
	logic [`IRQ_W-1:0]        irq_clear;
	logic                     aw_held_q;
	logic                     w_held_q;
	logic [`ADDR_W-1:0]       awaddr_q;
	logic [31:0]              wdata_q;
	logic [3:0]               wstrb_q;
	logic                     wr_go;

	reset_sequencer #(
		.MIN_CYC (RESET_MIN_CYC),
		.MAX_CYC (RESET_MAX_CYC)
	) u_seq (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.input_closed (reset_input_closed),
		.valid_pulse  (valid_pulse)
	);

	// a single noisy scan is ignored, a run of them counts as a blocked curtain
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			noise_cnt_q <= 4'h0;
		end else if (scan_strobe) begin
			if (!beams.noise) begin
				noise_cnt_q <= 4'h0;
			end else if (noise_cnt_q < `NOISE_SCANS) begin
				noise_cnt_q <= noise_cnt_q + 4'h1;
			end
		end
	end

	assign blocked  = beams.any_blocked || noise_cnt_q >= `NOISE_SCANS;
	assign rx_fault = faults.output_f || faults.optical_f || faults.internal_f;

	// emitter lockout survives any reset sequence, only aresetn clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			emit_lock_q <= 1'b0;
		end else if (faults.emitter_f) begin
			emit_lock_q <= 1'b1;
		end
	end

	// beams must be clear in the first closed cycle and in the valid_pulse cycle; bad_q clears before the pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bad_q <= 1'b0;
		end else if (blocked) begin
			bad_q <= 1'b1;
		end else if (reset_input_closed && !valid_pulse) begin
			bad_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			test_q <= 1'b0;
		end else begin
			test_q <= !reset_input_closed;
		end
	end

	assign reset_ok = valid_pulse && !bad_q && !blocked;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= lc_pkg::ST_POWERUP;
		end else begin
			case (state_q)
				lc_pkg::ST_POWERUP: begin
					if (!reset_input_closed) begin
						state_q <= lc_pkg::ST_INPUT_FAULT;
					end else if (rx_fault || faults.emitter_f) begin
						state_q <= lc_pkg::ST_LOCKOUT;
					end else if (latch_mode_q) begin
						state_q <= lc_pkg::ST_LATCHED;
					end else begin
						state_q <= lc_pkg::ST_RUN;
					end
				end
				lc_pkg::ST_INPUT_FAULT: begin
					state_q <= lc_pkg::ST_INPUT_FAULT;
				end
				lc_pkg::ST_RUN: begin
					if (rx_fault || emit_lock_q) begin
						state_q <= lc_pkg::ST_LOCKOUT;
					end else if (latch_mode_q && (blocked || !reset_input_closed)) begin
						state_q <= lc_pkg::ST_LATCHED;
					end
				end
				lc_pkg::ST_LATCHED: begin
					if (rx_fault || emit_lock_q) begin
						state_q <= lc_pkg::ST_LOCKOUT;
					end else if (reset_ok) begin
						state_q <= lc_pkg::ST_RUN;
					end
				end
				lc_pkg::ST_LOCKOUT: begin
					if (valid_pulse && !rx_fault && !emit_lock_q) begin
						state_q <= latch_mode_q ? lc_pkg::ST_LATCHED
							: lc_pkg::ST_RUN;
					end
				end
				default: begin
					state_q <= lc_pkg::ST_LOCKOUT;
				end
			endcase
		end
	end

	// first fault seen picks the pattern, output fault outranks optical
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cause_q <= lc_pkg::CAUSE_NONE;
		end else if (state_q != lc_pkg::ST_LOCKOUT) begin
			if (faults.output_f) begin
				cause_q <= lc_pkg::CAUSE_OUTPUT;
			end else if (faults.optical_f) begin
				cause_q <= lc_pkg::CAUSE_OPTICAL;
			end else begin
				cause_q <= lc_pkg::CAUSE_INTERNAL;
			end
		end
	end

	// faults are checked live so that off wins even before lockout is entered
	assign out_on_d = state_q == lc_pkg::ST_RUN && !blocked && reset_input_closed
		&& !rx_fault && !faults.emitter_f && !emit_lock_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			safety_output_a <= 1'b0;
			safety_output_b <= 1'b0;
		end else begin
			safety_output_a <= out_on_d;
			safety_output_b <= out_on_d;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q     <= 1'b0;
		end else if (flash_cnt_q >= FLASH_CYC - 1) begin
			flash_cnt_q <= 32'h0000_0000;
			flash_q     <= !flash_q;
		end else begin
			flash_cnt_q <= flash_cnt_q + 32'h0000_0001;
		end
	end

	always_comb begin
		leds_d = '{top: beams.top_clear, bottom: beams.bottom_clear,
			red: blocked, green: !blocked};
		case (state_q)
			lc_pkg::ST_POWERUP: begin
				leds_d = '{top: 1'b0, bottom: 1'b0, red: 1'b0, green: 1'b0};
			end
			lc_pkg::ST_INPUT_FAULT: begin
				leds_d = '{top: 1'b0, bottom: 1'b0, red: 1'b1, green: 1'b1};
			end
			lc_pkg::ST_LOCKOUT: begin
				case (cause_q)
					lc_pkg::CAUSE_OUTPUT:
						leds_d = '{top: flash_q, bottom: flash_q,
							red: flash_q, green: 1'b0};
					lc_pkg::CAUSE_OPTICAL:
						leds_d = '{top: flash_q, bottom: 1'b0,
							red: flash_q, green: 1'b0};
					default:
						leds_d = '{top: 1'b0, bottom: 1'b0,
							red: flash_q, green: 1'b0};
				endcase
			end
			lc_pkg::ST_LATCHED: begin
				if (!reset_input_closed) begin
					leds_d = '{top: 1'b0, bottom: 1'b0, red: 1'b1, green: flash_q};
				end else if (!blocked) begin
					leds_d = '{top: flash_q, bottom: flash_q,
						red: 1'b0, green: 1'b1};
				end
			end
			default: begin
				if (!reset_input_closed) begin
					leds_d = '{top: 1'b0, bottom: 1'b0, red: 1'b1, green: flash_q};
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			leds        <= '{top: 1'b0, bottom: 1'b0, red: 1'b0, green: 1'b0};
			emitter_led <= 1'b0;
		end else begin
			leds        <= leds_d;
			emitter_led <= emit_lock_q ? flash_q : 1'b1;
		end
	end

	// interrupt sources
	assign irq_event[`IRQ_TRIP]     = safety_output_a && !out_on_d;
	assign irq_event[`IRQ_LOCKOUT]  = state_q != lc_pkg::ST_LOCKOUT
		&& state_q != lc_pkg::ST_INPUT_FAULT
		&& (rx_fault || faults.emitter_f || emit_lock_q);
	assign irq_event[`IRQ_RESET_OK] = valid_pulse && state_q != lc_pkg::ST_RUN
		&& state_q != lc_pkg::ST_INPUT_FAULT;
	assign irq_event[`IRQ_TEST]     = !reset_input_closed && !test_q;
	assign irq_clear = (wr_go && awaddr_q == `REG_IRQ_CLEAR && wstrb_q[0])
		? wdata_q[`IRQ_W-1:0] : {`IRQ_W{1'b0}};

	// a new event beats a clear landing in the same cycle
	for (genvar i = 0; i < `IRQ_W; i++) begin : g_irq
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				irq_status_q[i] <= 1'b0;
			end else if (irq_event[i]) begin
				irq_status_q[i] <= 1'b1;
			end else if (irq_clear[i]) begin
				irq_status_q[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_enable_q);
		end
	end

	// write channel: address and data taken in either order, then one response
	assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q     <= 1'b0;
			s_axi_awready <= 1'b1;
			awaddr_q      <= {`ADDR_W{1'b0}};
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q     <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_q      <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_held_q     <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q     <= 1'b0;
			s_axi_wready <= 1'b1;
			wdata_q      <= 32'h0000_0000;
			wstrb_q      <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q     <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_q      <= s_axi_wdata;
			wstrb_q      <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held_q     <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (awaddr_q == `REG_CTRL || awaddr_q == `REG_IRQ_CLEAR
				|| awaddr_q == `REG_IRQ_ENABLE) ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			latch_mode_q <= `CTRL_RESET;
			irq_enable_q <= `IRQ_EN_RESET;
		end else if (wr_go && wstrb_q[0]) begin
			if (awaddr_q == `REG_CTRL) begin
				latch_mode_q <= wdata_q[`CTRL_LATCH_BIT];
			end
			if (awaddr_q == `REG_IRQ_ENABLE) begin
				irq_enable_q <= wdata_q[`IRQ_W-1:0];
			end
		end
	end

	// read channel, one answer per address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= `RESP_OKAY;
			s_axi_rdata   <= 32'h0000_0000;
			case (s_axi_araddr)
				`REG_CTRL:       s_axi_rdata[`CTRL_LATCH_BIT] <= latch_mode_q;
				`REG_STATUS: begin
					s_axi_rdata[`ST_STATE_LSB +: 3] <= state_q;
					s_axi_rdata[`ST_OUT_BIT]         <= safety_output_a;
					s_axi_rdata[`ST_LED_LSB +: 4]    <= leds;
					s_axi_rdata[`ST_EMIT_LED_BIT]    <= emitter_led;
					s_axi_rdata[`ST_CAUSE_LSB +: 2]  <= cause_q;
					s_axi_rdata[`ST_TEST_BIT]        <= test_q;
				end
				`REG_IRQ_STATUS: s_axi_rdata[`IRQ_W-1:0] <= irq_status_q;
				`REG_IRQ_CLEAR:  s_axi_rdata <= 32'h0000_0000;
				`REG_IRQ_ENABLE: s_axi_rdata[`IRQ_W-1:0] <= irq_enable_q;
				default:         s_axi_rresp <= `RESP_SLVERR;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule // light_curtain_ctrl
`default_nettype wire

// File: light_curtain_ctrl_checker.sv
// concurrent assertions on the receiver control ports, bound into the design
`timescale 1ns/1ps
`default_nettype none
module light_curtain_ctrl_checker (
	// clock and reset
	input wire logic           aclk,
	input wire logic           aresetn,
	// scanner, faults, switch
	input wire lc_pkg::beams_t beams,
	input wire lc_pkg::fault_t faults,
	input wire logic           reset_input_closed,
	// outputs and indicators
	input wire logic           safety_output_a,
	input wire logic           safety_output_b,
	input wire lc_pkg::led_t   leds,
	// write response
	input wire logic           s_axi_bvalid,
	input wire logic           s_axi_bready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// fault held with the switch closed, so no reset can be under way
	sequence out_fault_held;
		(faults.output_f && reset_input_closed)[*3];
	endsequence

	AST_OUT_PAIR: assert property (safety_output_a == safety_output_b)
		else $error("safety outputs disagree");
	AST_BLOCK_OFF: assert property (beams.any_blocked |=> !safety_output_a)
		else $error("outputs on after a blocked beam");
	AST_FAULT_OFF: assert property (faults != 4'h0 |=> !safety_output_a)
		else $error("outputs on while a fault is present");
	AST_OPEN_OFF: assert property (!reset_input_closed |=> !safety_output_b)
		else $error("outputs on while the switch is open");
	AST_ON_CAUSE: assert property ($rose(safety_output_a) |-> $past(reset_input_closed)
		&& !$past(beams.any_blocked) && $past(faults) == 4'h0)
		else $error("outputs rose without clean inputs");
	AST_ON_LEDS: assert property (safety_output_a && $past(safety_output_a)
		|-> leds.green && !leds.red)
		else $error("status leds wrong while outputs on");
	AST_OUT_FAULT_LED: assert property (out_fault_held |-> !leds.green)
		else $error("green lit during output fault");
	AST_BRESP_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
endmodule // light_curtain_ctrl_checker

bind light_curtain_ctrl light_curtain_ctrl_checker u_chk (.aclk, .aresetn, .beams, .faults,
	.reset_input_closed, .safety_output_a, .safety_output_b, .leds, .s_axi_bvalid,
	.s_axi_bready);
`default_nettype wire

// File: light_curtain_ctrl_tb.sv
// self-checking bench for the light-curtain receiver control block
`include "lc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module light_curtain_ctrl_tb;
	logic           aclk;
	logic           aresetn = 1'h0;
	lc_pkg::beams_t beams = 4'hC;
	logic           scan_strobe = 1'h0;
	lc_pkg::fault_t faults = 4'h0;
	wire logic      closed, machine_run;
	logic           safety_output_a, safety_output_b, emitter_led, irq;
	lc_pkg::led_t   leds;
	logic [7:0]     s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]     s_axi_wstrb = 4'hF;
	logic           s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic           s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]     s_axi_bresp, s_axi_rresp;
	logic [31:0]    d;
	int             n_fail = 0;
	int             n_compared = 0;

	light_curtain_ctrl #(.RESET_MIN_CYC(10), .RESET_MAX_CYC(80), .FLASH_CYC(4)) DUT (
		.aclk, .aresetn, .beams, .scan_strobe, .faults, .reset_input_closed(closed),
		.safety_output_a, .safety_output_b, .leds, .emitter_led, .irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	machine_side_model sw (.aclk, .out_a(safety_output_a), .out_b(safety_output_b), .closed,
		.machine_run);

	initial begin
		aclk = 1'h0;
		forever #12.5 aclk = ~aclk;
	end

	task automatic summarize;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp1(input logic got, input logic exp);
		cmp({31'h0, got}, {31'h0, exp});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'h0;
		cmp({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'h1, er});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'h0;
		v = s_axi_rdata;
		cmp({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'h1, er});
	endtask
	task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v, `RESP_OKAY);
		cmp(v & m, e);
	endtask
	task automatic wait_out(input logic e);
		int n;
		for (n = 0; n < 30 && safety_output_a !== e; n++) @(posedge aclk);
		cmp1(safety_output_a, e);
	endtask
	task automatic scan(input logic [3:0] b);
		@(posedge aclk);
		beams <= b;
		scan_strobe <= 1'h1;
		@(posedge aclk);
		scan_strobe <= 1'h0;
	endtask
	// {outputs, top, bottom, red, green, emitter}: or shows lit, and shows steady
	task automatic watch(input logic [5:0] eo, input logic [5:0] ea);
		logic [5:0] o, a;
		int n;
		o = 6'h00;
		a = 6'h3F;
		for (n = 0; n < 12; n++) begin
			@(posedge aclk);
			o = o | {safety_output_a, leds, emitter_led};
			a = a & {safety_output_a, leds, emitter_led};
		end
		cmp({26'h0, o}, {26'h0, eo});
		cmp({26'h0, a}, {26'h0, ea});
	endtask
	task automatic do_reset;
		@(posedge aclk);
		aresetn <= 1'h0;
		idle(8);
		aresetn <= 1'h1;
		idle(2);
	endtask

	task automatic t_regs;
		chk_reg(`REG_CTRL, 32'hFFFFFFFF, 32'h0);
		chk_reg(`REG_IRQ_ENABLE, 32'hFFFFFFFF, 32'h0);
		rd(8'h14, d, `RESP_SLVERR);
		cmp(d, 32'h0);
		rd(8'hE3, d, `RESP_SLVERR);
		cmp(d, 32'h0);
		wr(`REG_STATUS, 32'h0, `RESP_SLVERR);
		// lane 0 strobe low: the write is answered but ignored
		s_axi_wstrb <= 4'h0;
		wr(`REG_CTRL, 32'h1, `RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		wr(`REG_IRQ_ENABLE, 32'hFFFFFFF0, `RESP_OKAY);
		chk_reg(`REG_CTRL, 32'hFFFFFFFF, 32'h0);
		chk_reg(`REG_IRQ_ENABLE, 32'hFFFFFFFF, 32'h0);
		chk_reg(`REG_IRQ_CLEAR, 32'hFFFFFFFF, 32'h0);
		chk_reg(`REG_STATUS, 32'hF, 32'hA);
		$display("regs done");
	endtask
	task automatic t_trip;
		wr(`REG_IRQ_ENABLE, 32'h1, `RESP_OKAY);
		scan(4'h2);
		wait_out(1'h0);
		scan(4'hC);
		wait_out(1'h1);
		idle(2);
		cmp1(machine_run, 1'h1);
		cmp1(irq, 1'h1);
		wr(`REG_IRQ_CLEAR, 32'h1, `RESP_OKAY);
		idle(2);
		cmp1(irq, 1'h0);
		wr(`REG_IRQ_ENABLE, 32'h0, `RESP_OKAY);
		scan(4'h2);
		wait_out(1'h0);
		scan(4'hC);
		wait_out(1'h1);
		cmp1(irq, 1'h0);
		chk_reg(`REG_IRQ_STATUS, 32'h1, 32'h1);
		$display("trip done");
	endtask
	task automatic t_noise;
		scan(4'hD);
		scan(4'hD);
		scan(4'hC);
		scan(4'hD);
		scan(4'hD);
		idle(2);
		cmp1(safety_output_a, 1'h1);
		scan(4'hD);
		wait_out(1'h0);
		scan(4'hC);
		wait_out(1'h1);
		$display("noise done");
	endtask
	task automatic t_test;
		wr(`REG_IRQ_CLEAR, 32'hF, `RESP_OKAY);
		sw.set_switch(1'h0);
		idle(4);
		cmp({28'h0, leds.red, leds.top, leds.bottom, safety_output_a}, 32'h8);
		chk_reg(`REG_IRQ_STATUS, 32'h8, 32'h8);
		sw.set_switch(1'h1);
		wait_out(1'h1);
		// reset events only count outside run, so judge the window while latched
		wr(`REG_CTRL, 32'h1, `RESP_OKAY);
		sw.open_for(100);
		idle(10);
		cmp1(safety_output_a, 1'h0);
		chk_reg(`REG_IRQ_STATUS, 32'h4, 32'h0);
		sw.open_for(20);
		wait_out(1'h1);
		chk_reg(`REG_IRQ_STATUS, 32'h4, 32'h4);
		wr(`REG_CTRL, 32'h0, `RESP_OKAY);
		$display("test mode done");
	endtask
	task automatic t_lockout;
		logic [3:0] f[3] = '{4'h8, 4'h4, 4'h2};
		logic [5:0] p[3] = '{6'h1D, 6'h15, 6'h05};
		for (int i = 0; i < 3; i++) begin
			@(posedge aclk);
			faults <= f[i];
			idle(3);
			watch(p[i], 6'h01);
			chk_reg(`REG_STATUS, 32'h607, 32'(i + 1) << 9 | 32'h4);
			@(posedge aclk);
			faults <= 4'h0;
			sw.open_for(20);
			wait_out(1'h1);
		end
		$display("lockout done");
	endtask
	task automatic t_latch;
		wr(`REG_CTRL, 32'h1, `RESP_OKAY);
		scan(4'h2);
		wait_out(1'h0);
		scan(4'hC);
		idle(3);
		watch(6'h1B, 6'h03);
		scan(4'h2);
		sw.open_for(20);
		scan(4'hC);
		idle(10);
		cmp1(safety_output_a, 1'h0);
		sw.open_for(20);
		wait_out(1'h1);
		@(posedge aclk);
		faults <= 4'h2;
		idle(3);
		faults <= 4'h0;
		sw.open_for(20);
		idle(10);
		cmp1(safety_output_a, 1'h0);
		sw.open_for(20);
		wait_out(1'h1);
		$display("latch done");
	endtask
	task automatic t_power;
		sw.set_switch(1'h0);
		do_reset();
		watch(6'h07, 6'h07);
		sw.set_switch(1'h1);
		idle(5);
		chk_reg(`REG_STATUS, 32'h7, 32'h1);
		do_reset();
		wait_out(1'h1);
		@(posedge aclk);
		faults <= 4'h1;
		idle(3);
		faults <= 4'h0;
		watch(6'h05, 6'h00);
		sw.open_for(20);
		idle(10);
		cmp1(safety_output_a, 1'h0);
		do_reset();
		wait_out(1'h1);
		$display("power done");
	endtask

	// run takes a few hundred cycles
	initial begin
		idle(20000);
		n_fail++;
		summarize();
	end
	initial begin
		idle(8);
		aresetn <= 1'h1;
		wait_out(1'h1);
		t_regs();
		t_trip();
		t_noise();
		t_test();
		t_lockout();
		t_latch();
		t_power();
		summarize();
	end
endmodule // light_curtain_ctrl_tb
`default_nettype wire

// File: machine_side_model.sv
// reset switch and guarded machine seen from the receiver outputs
`timescale 1ns/1ps
`default_nettype none
module machine_side_model (
	// clock
	input wire logic aclk,
	// receiver outputs
	input wire logic out_a,
	input wire logic out_b,
	// switch and machine
	output var logic closed,
	output var logic machine_run
);
	initial closed = 1'h1;
	// machine only runs while both channels say go
	always @(posedge aclk) machine_run <= out_a & out_b;
	task automatic set_switch(input logic v);
		@(posedge aclk);
		closed <= v;
	endtask
	task automatic open_for(input int n);
		set_switch(1'h0);
		repeat (n) @(posedge aclk);
		closed <= 1'h1;
	endtask
endmodule // machine_side_model
`default_nettype wire

// File: reset_sequencer.sv
// times the open phase of the reset/test input and flags a valid reset
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer #(
	parameter int unsigned MIN_CYC = 10000000,
	parameter int unsigned MAX_CYC = 80000000
) (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// reset/test input, high while closed
	input  wire logic input_closed,
	// result
	output logic      valid_pulse
);
	logic [31:0] open_cnt_q;
	logic        was_open_q;

	// count saturates just past the window so long opens stay rejected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			open_cnt_q <= 32'h0000_0000;
		end else if (input_closed) begin
			open_cnt_q <= 32'h0000_0000;
		end else if (open_cnt_q <= MAX_CYC) begin
			open_cnt_q <= open_cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			was_open_q <= 1'b0;
		end else begin
			was_open_q <= !input_closed;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid_pulse <= 1'b0;
		end else begin
			valid_pulse <= was_open_q && input_closed
				&& open_cnt_q >= MIN_CYC && open_cnt_q <= MAX_CYC;
		end
	end
endmodule // reset_sequencer
`default_nettype wire
